// ### dv/oasl_pipe_model.sv
// partner model: working register file of the core pipeline
`timescale 1ns/10ps
module oasl_pipe_model (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              loadEn,
  input  wire logic [3:0]        loadIdx,
  input  wire logic [15:0]       loadVal,
  output logic      [15:0][15:0] wregs
);
  logic [15:0][15:0] wregs_q;
  logic [15:0][15:0] wregs_d;
  // ***********************************************
  // register file update
  // ***********************************************
  // pointers stay in space
  always_comb begin
    wregs_d = wregs_q;
    if (loadEn) begin
      wregs_d[loadIdx] = loadVal;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wregs_q <= '0;
    end else begin
      wregs_q <= wregs_d;
    end
  end
  assign wregs = wregs_q;
endmodule // oasl_pipe_model

// ### dv/operand_address_stall_logic_tb.sv
// testbench: register bus, stall table, operand routing and circular checks
`timescale 1ns/10ps
module operand_address_stall_logic_tb;
  logic ref_clk, srst, hsel, hwrite, loadEn, stall, holdPredecode, macIllegal, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] instrWord;
  logic [3:0] loadIdx;
  logic [15:0] loadVal, xReadAddr, yReadAddr, xPtrNext, yPtrNext, movSrcEa, movDstEa, xWriteAddr;
  logic signed [15:0] branchDisp;
  logic [13:0] disiCount;
  logic [15:0][15:0] wregs;
  logic exp;
  oasl_pkg::oasl_dst_type exeDst;
  oasl_pkg::oasl_src_type preSrc;
  oasl_pkg::oasl_mac_type macOp;
  oasl_pkg::oasl_mov_type movOp;
  int n_fail, check_count, nStall;
  logic [15:0] cCtl [5] = '{16'h80F8, 16'hC0A8, 16'hC0AF, 16'h00A8, 16'hC0A8};
  logic [15:0] cPtr [5] = '{16'h201C, 16'h201C, 16'h201C, 16'h201C, 16'h2000};
  logic [15:0] cX [5] = '{16'h2002, 16'h2002, 16'h2022, 16'h2022, 16'h201E};
  logic [15:0] cY [5] = '{16'h3022, 16'h3002, 16'h3002, 16'h3022, 16'h301E};

  oasl_core dut_u (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wregs(wregs), .exeDst(exeDst),
    .preSrc(preSrc), .macOp(macOp), .movOp(movOp), .instrWord(instrWord), .stall(stall),
    .holdPredecode(holdPredecode), .xReadAddr(xReadAddr), .yReadAddr(yReadAddr),
    .xPtrNext(xPtrNext), .yPtrNext(yPtrNext), .macIllegal(macIllegal), .movSrcEa(movSrcEa),
    .movDstEa(movDstEa), .xWriteAddr(xWriteAddr), .branchDisp(branchDisp),
    .disiCount(disiCount));
  oasl_pipe_model pm_u (.ref_clk(ref_clk), .srst(srst), .loadEn(loadEn), .loadIdx(loadIdx),
    .loadVal(loadVal), .wregs(wregs));

  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic waitRdy();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_fail++;
        complete_run();
      end
      @(posedge ref_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= oasl_pkg::AHB_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic setw(input logic [3:0] i, input logic [15:0] v);
    @(posedge ref_clk);
    loadEn <= 1'b1;
    loadIdx <= i;
    loadVal <= v;
    @(posedge ref_clk);
    loadEn <= 1'b0;
  endtask
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    {srst, hsel, hwrite, loadEn, htrans, haddr, hwdata, loadIdx, loadVal} = '0;
    {exeDst, preSrc, macOp, movOp, instrWord, n_fail, check_count, nStall} = '0;
    srst = 1'b1;
    hsize = 3'h2;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, oasl_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h0000_00FF);
    bus(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    chk(hresp, 1'b0);
    $display("test registers done");
    for (int dm = 0; dm < 4; dm++) begin
      for (int sm = 0; sm < 4; sm++) begin
        for (int k = 0; k < 3; k++) begin
          @(posedge ref_clk);
          exeDst <= '{1'b1, oasl_pkg::oasl_mode_type'(dm), 4'h2, 1'b1,
                      (k == 1) ? 16'h0004 : 16'h0040};
          preSrc <= '{1'b1, oasl_pkg::oasl_mode_type'(sm), (k == 2) ? 4'h3 : 4'h2};
          exp = (sm != 0) && (k != 2) && (dm == 0 || dm == 3 || k == 1);
          nStall += exp;
          settle(); chk(stall, exp);
          chk(holdPredecode, exp);
          @(posedge ref_clk);
          exeDst.valid <= 1'b0;
          #1; chk(stall, 1'b0);
        end
      end
    end
    bus(1'b0, oasl_pkg::ADDR_STATUS, 32'h0); chk(rd & 32'h0000_FFFF, 32'(nStall));
    $display("test stall table done");
    setw(4'h8, 16'h1000);
    setw(4'hB, 16'h3000);
    setw(4'h3, 16'h0010);
    for (int s = 1; s < 4; s++) begin
      @(posedge ref_clk);
      macOp <= '{1'b1, 1'b0, 1'b1, oasl_pkg::AM_MODIFIED, oasl_pkg::AM_INDEXED,
                 2'(s), 1'b0, 4'h3};
      settle(); chk(xReadAddr, 16'h1000);
      chk(yReadAddr, 16'h3010);
      chk(xPtrNext, 16'h1000 + 16'(2 * s));
      chk(macIllegal, 1'b0);
    end
    @(posedge ref_clk);
    macOp <= '{1'b1, 1'b0, 1'b1, oasl_pkg::AM_INDIRECT, oasl_pkg::AM_INDIRECT,
               2'h1, 1'b0, 4'h3};
    settle(); chk(xReadAddr, 16'h1000);
    chk(yReadAddr, 16'h3000);
    chk(xPtrNext, 16'h1000);
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      macOp <= '{1'b1, s[0], s[1], oasl_pkg::AM_INDEXED, oasl_pkg::AM_INDEXED,
                 2'h1, 1'b0, 4'h3};
      settle(); chk(macIllegal, !(s[0] && s[1]));
    end
    $display("test operand routing done");
    bus(1'b1, oasl_pkg::ADDR_XSTART, 32'h0000_2000);
    bus(1'b1, oasl_pkg::ADDR_XEND, 32'h0000_201F);
    bus(1'b1, oasl_pkg::ADDR_YSTART, 32'h0000_3000);
    bus(1'b1, oasl_pkg::ADDR_YEND, 32'h0000_301F);
    for (int r = 0; r < 5; r++) begin
      bus(1'b1, oasl_pkg::ADDR_CTRL, {16'h0000, cCtl[r]});
      setw(4'h8, cPtr[r]);
      setw(4'hA, cPtr[r] + 16'h1000);
      @(posedge ref_clk);
      macOp <= '{1'b1, 1'b0, 1'b0, oasl_pkg::AM_MODIFIED, oasl_pkg::AM_MODIFIED,
                 (r == 4) ? 2'h1 : 2'h3, r == 4, 4'h3};
      settle(); chk(xPtrNext, cX[r]);
      chk(yPtrNext, cY[r]);
    end
    bus(1'b0, oasl_pkg::ADDR_CTRL, 32'h0); chk(rd, 32'h0000_C0A8);
    $display("test circular done");
    setw(4'h4, 16'h0100);
    setw(4'h5, 16'h0200);
    setw(4'h6, 16'h0022);
    @(posedge ref_clk);
    movOp <= '{oasl_pkg::AM_INDEXED, 4'h4, oasl_pkg::AM_INDIRECT, 4'h5, 4'h6};
    instrWord <= 24'h00_8ABC;
    exeDst <= '{1'b0, oasl_pkg::AM_DIRECT, 4'h0, 1'b1, 16'h1234};
    settle(); chk(movSrcEa, 16'h0122);
    chk(movDstEa, 16'h0200);
    chk(xWriteAddr, 16'h1234);
    chk(branchDisp, 32'hFFFF_8ABC);
    chk(disiCount, 14'h0ABC);
    $display("test move and literals done");
    complete_run();
  end
endmodule // operand_address_stall_logic_tb

// ### logic/oasl_core.sv
// module: operand routing, raw stall detection and circular addressing
`timescale 1ns/10ps
module oasl_core (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic [15:0][15:0]         wregs,
  input  wire oasl_pkg::oasl_dst_type    exeDst,
  input  wire oasl_pkg::oasl_src_type    preSrc,
  input  wire oasl_pkg::oasl_mac_type    macOp,
  input  wire oasl_pkg::oasl_mov_type    movOp,
  input  wire logic [23:0]               instrWord,
  output logic                           stall,
  output logic                           holdPredecode,
  output logic      [15:0]               xReadAddr,
  output logic      [15:0]               yReadAddr,
  output logic      [15:0]               xPtrNext,
  output logic      [15:0]               yPtrNext,
  output logic                           macIllegal,
  output logic      [15:0]               movSrcEa,
  output logic      [15:0]               movDstEa,
  output logic      [15:0]               xWriteAddr,
  output logic signed [15:0]             branchDisp,
  output logic      [13:0]               disiCount
);
  // ***********************************************
  // circular correction
  // ***********************************************
  function automatic logic [15:0] circFix(input logic [15:0] ea, input logic [15:0] lo,
                                          input logic [15:0] hi, input logic neg,
                                          input logic on);
    logic [15:0] len;
    logic        pow2;
    len  = 16'(hi - lo + 16'h0001);
    pow2 = ((len & 16'(len - 16'h0001)) == 16'h0000) && ((lo & 16'(len - 16'h0001)) == 16'h0000);
    circFix = ea;
    if (on && (!neg || pow2) && (ea > hi)) begin
      circFix = 16'(ea - len);
    end else if (on && (neg || pow2) && (ea < lo)) begin
      circFix = 16'(ea + len);
    end
  endfunction

  // ***********************************************
  // bus slave
  // ***********************************************
  logic [15:0] ctrl_q, ctrl_d, xStart_q, xStart_d, xEnd_q, xEnd_d;
  logic [15:0] yStart_q, yStart_d, yEnd_q, yEnd_d, stallCnt_q, stallCnt_d;
  logic [7:0]  wAddr_q, wAddr_d;
  logic        wPend_q, wPend_d;
  logic [31:0] rdata_d;
  logic        take;

  assign take = hsel && hready && (htrans == oasl_pkg::AHB_NONSEQ);

  always_comb begin
    ctrl_d   = ctrl_q;
    xStart_d = xStart_q;
    xEnd_d   = xEnd_q;
    yStart_d = yStart_q;
    yEnd_d   = yEnd_q;
    wPend_d  = take && hwrite;
    wAddr_d  = haddr[oasl_pkg::DEC_BITS-1:0];
    rdata_d  = 32'h0000_0000;
    if (wPend_q) begin
      unique case (wAddr_q)
        oasl_pkg::ADDR_CTRL:   ctrl_d   = hwdata[15:0];
        oasl_pkg::ADDR_XSTART: xStart_d = hwdata[15:0];
        oasl_pkg::ADDR_XEND:   xEnd_d   = hwdata[15:0];
        oasl_pkg::ADDR_YSTART: yStart_d = hwdata[15:0];
        oasl_pkg::ADDR_YEND:   yEnd_d   = hwdata[15:0];
        default:               ;
      endcase
    end
    if (take && !hwrite && (haddr[31:oasl_pkg::DEC_BITS] == '0)) begin
      unique case (haddr[oasl_pkg::DEC_BITS-1:0])
        oasl_pkg::ADDR_CTRL:   rdata_d = {16'h0000, ctrl_q};
        oasl_pkg::ADDR_XSTART: rdata_d = {16'h0000, xStart_q};
        oasl_pkg::ADDR_XEND:   rdata_d = {16'h0000, xEnd_q};
        oasl_pkg::ADDR_YSTART: rdata_d = {16'h0000, yStart_q};
        oasl_pkg::ADDR_YEND:   rdata_d = {16'h0000, yEnd_q};
        oasl_pkg::ADDR_STATUS: rdata_d = {14'h0000, macIllegal, stall, stallCnt_q};
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
    if (take && hwrite && (haddr[31:oasl_pkg::DEC_BITS] != '0)) begin
      wPend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q    <= oasl_pkg::CTRL_RST;
      xStart_q  <= oasl_pkg::BOUND_RST;
      xEnd_q    <= oasl_pkg::BOUND_RST;
      yStart_q  <= oasl_pkg::BOUND_RST;
      yEnd_q    <= oasl_pkg::BOUND_RST;
      wPend_q   <= 1'b0;
      wAddr_q   <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      xStart_q  <= xStart_d;
      xEnd_q    <= xEnd_d;
      yStart_q  <= yStart_d;
      yEnd_q    <= yEnd_d;
      wPend_q   <= wPend_d;
      wAddr_q   <= wAddr_d;
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ***********************************************
  // raw stall detection
  // ***********************************************
  logic        sameReg, selfMap, hazard, stall_d;
  logic [15:0] mapAddr;

  always_comb begin
    sameReg = exeDst.valid && preSrc.valid && (exeDst.wreg == preSrc.wreg);
    mapAddr = 16'(oasl_pkg::WMAP_BASE + (16'(exeDst.wreg) << oasl_pkg::WMAP_SHIFT));
    selfMap = exeDst.writePhase && (exeDst.wrAddr == mapAddr);
    hazard  = 1'b0;
    if (sameReg && (preSrc.mode != oasl_pkg::AM_DIRECT)) begin
      unique case (exeDst.mode)
        oasl_pkg::AM_DIRECT:   hazard = 1'b1;
        oasl_pkg::AM_INDIRECT: hazard = selfMap;
        oasl_pkg::AM_MODIFIED: hazard = 1'b1;
        oasl_pkg::AM_INDEXED:  hazard = selfMap;
      endcase
    end
    stall_d    = hazard && !stall;
    stallCnt_d = stall_d ? 16'(stallCnt_q + 16'h0001) : stallCnt_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stall         <= 1'b0;
      holdPredecode <= 1'b0;
      stallCnt_q    <= 16'h0000;
    end else begin
      stall         <= stall_d;
      holdPredecode <= stall_d;
      stallCnt_q    <= stallCnt_d;
    end
  end

  // ***********************************************
  // operand address generation
  // ***********************************************
  logic [15:0] xBase, yBase, xEa_d, yEa_d, xNext_d, yNext_d, step16;
  logic [15:0] movSrc_d, movDst_d, xWr_d;
  logic        xOn, yOn, illegal_d;

  always_comb begin
    xBase  = wregs[macOp.xSelB ? oasl_pkg::X_PTR_B : oasl_pkg::X_PTR_A];
    yBase  = wregs[macOp.ySelB ? oasl_pkg::Y_PTR_B : oasl_pkg::Y_PTR_A];
    xOn = ctrl_q[oasl_pkg::XEN_BIT] && (ctrl_q[oasl_pkg::XSEL_LO+:4] != oasl_pkg::SEL_OFF);
    yOn = ctrl_q[oasl_pkg::YEN_BIT] && (ctrl_q[oasl_pkg::YSEL_LO+:4] != oasl_pkg::SEL_OFF);
    // step of 0, 2, 4 or 6
    step16 = {13'h0000, macOp.step, 1'b0};
    xEa_d   = xBase;
    yEa_d   = yBase;
    xNext_d = xBase;
    yNext_d = yBase;
    illegal_d = macOp.valid && ((macOp.xMode == oasl_pkg::AM_INDEXED && !macOp.xSelB) ||
                                (macOp.yMode == oasl_pkg::AM_INDEXED && !macOp.ySelB));
    if (macOp.xMode == oasl_pkg::AM_INDEXED) begin
      xEa_d = 16'(xBase + wregs[macOp.offReg]);
    end else if (macOp.xMode == oasl_pkg::AM_MODIFIED) begin
      xNext_d = macOp.stepNeg ? 16'(xBase - step16) : 16'(xBase + step16);
    end
    if (macOp.yMode == oasl_pkg::AM_INDEXED) begin
      yEa_d = 16'(yBase + wregs[macOp.offReg]);
    end else if (macOp.yMode == oasl_pkg::AM_MODIFIED) begin
      yNext_d = macOp.stepNeg ? 16'(yBase - step16) : 16'(yBase + step16);
    end
    xEa_d   = circFix(xEa_d, xStart_q, xEnd_q, macOp.stepNeg,
                      xOn && (ctrl_q[oasl_pkg::XSEL_LO+:4] == (macOp.xSelB ?
                      oasl_pkg::X_PTR_B : oasl_pkg::X_PTR_A)));
    xNext_d = circFix(xNext_d, xStart_q, xEnd_q, macOp.stepNeg,
                      xOn && (ctrl_q[oasl_pkg::XSEL_LO+:4] == (macOp.xSelB ?
                      oasl_pkg::X_PTR_B : oasl_pkg::X_PTR_A)));
    yEa_d   = circFix(yEa_d, yStart_q, yEnd_q, macOp.stepNeg,
                      yOn && (ctrl_q[oasl_pkg::YSEL_LO+:4] == (macOp.ySelB ?
                      oasl_pkg::Y_PTR_B : oasl_pkg::Y_PTR_A)));
    yNext_d = circFix(yNext_d, yStart_q, yEnd_q, macOp.stepNeg,
                      yOn && (ctrl_q[oasl_pkg::YSEL_LO+:4] == (macOp.ySelB ?
                      oasl_pkg::Y_PTR_B : oasl_pkg::Y_PTR_A)));
    movSrc_d = wregs[movOp.srcReg];
    movDst_d = wregs[movOp.dstReg];
    if (movOp.srcMode == oasl_pkg::AM_INDEXED) begin
      movSrc_d = 16'(movSrc_d + wregs[movOp.offsetRegisterField]);
    end
    if (movOp.dstMode == oasl_pkg::AM_INDEXED) begin
      movDst_d = 16'(movDst_d + wregs[movOp.offsetRegisterField]);
    end
    xWr_d = exeDst.writePhase ? exeDst.wrAddr : xWriteAddr;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xReadAddr  <= 16'h0000;
      yReadAddr  <= 16'h0000;
      xPtrNext   <= 16'h0000;
      yPtrNext   <= 16'h0000;
      macIllegal <= 1'b0;
      movSrcEa   <= 16'h0000;
      movDstEa   <= 16'h0000;
      xWriteAddr <= 16'h0000;
      branchDisp <= 16'sh0000;
      disiCount  <= 14'h0000;
    end else if (!stall_d) begin
      xReadAddr  <= xEa_d;
      yReadAddr  <= yEa_d;
      xPtrNext   <= xNext_d;
      yPtrNext   <= yNext_d;
      macIllegal <= illegal_d;
      movSrcEa   <= movSrc_d;
      movDstEa   <= movDst_d;
      xWriteAddr <= xWr_d;
      branchDisp <= signed'(instrWord[15:0]);
      disiCount  <= instrWord[13:0];
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  a_stall_single: assert property (@(posedge ref_clk) disable iff (srst)
    stall |=> !stall) else $error("stall lasted more than one cycle");
  a_direct_stall: assert property (@(posedge ref_clk) disable iff (srst)
    (!stall && sameReg && exeDst.mode == oasl_pkg::AM_DIRECT &&
     preSrc.mode != oasl_pkg::AM_DIRECT) |=> stall) else $error("direct write missed stall");
  a_direct_src: assert property (@(posedge ref_clk) disable iff (srst)
    (preSrc.valid && preSrc.mode == oasl_pkg::AM_DIRECT) |=> !stall)
    else $error("direct source stalled");
  a_indir_map: assert property (@(posedge ref_clk) disable iff (srst)
    (sameReg && exeDst.mode == oasl_pkg::AM_INDIRECT && !selfMap) |=> !stall)
    else $error("indirect write stalled without self map");
  a_mod_stall: assert property (@(posedge ref_clk) disable iff (srst)
    (!stall && sameReg && exeDst.mode == oasl_pkg::AM_MODIFIED &&
     preSrc.mode != oasl_pkg::AM_DIRECT) |=> stall) else $error("modified write missed stall");
  a_hold_stall: assert property (@(posedge ref_clk) disable iff (srst)
    holdPredecode == stall) else $error("hold differs from stall");
  a_stall_freeze: assert property (@(posedge ref_clk) disable iff (srst)
    stall |-> $stable(xReadAddr) && $stable(disiCount)) else $error("state moved in stall");
  a_index_legal: assert property (@(posedge ref_clk) disable iff (srst)
    (!stall_d && macOp.valid && macOp.xMode == oasl_pkg::AM_INDEXED && !macOp.xSelB)
    |=> macIllegal) else $error("indexed on first x pointer not flagged");
  a_x_route: assert property (@(posedge ref_clk) disable iff (srst)
    (!stall_d && !xOn && macOp.xMode == oasl_pkg::AM_INDIRECT && !macOp.xSelB)
    |=> xReadAddr == $past(wregs[oasl_pkg::X_PTR_A])) else $error("x pointer misrouted");
  a_circ_off: assert property (@(posedge ref_clk) disable iff (srst)
    (!stall_d && ctrl_q[oasl_pkg::XSEL_LO+:4] == oasl_pkg::SEL_OFF &&
     macOp.xMode == oasl_pkg::AM_INDIRECT && !macOp.xSelB)
    |=> xReadAddr == $past(wregs[oasl_pkg::X_PTR_A]))
    else $error("x circular on with select off");
  a_bus_ready: assert property (@(posedge ref_clk) disable iff (srst)
    hreadyout && !hresp) else $error("bus not ready or error");
endmodule // oasl_core

// ### logic/oasl_pkg.sv
// package: constants and carriers for the operand address and stall logic
package oasl_pkg;
  // ***********************************************
  // register map (byte addresses)
  // ***********************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_XSTART = 8'h04;
  localparam logic [7:0] ADDR_XEND   = 8'h08;
  localparam logic [7:0] ADDR_YSTART = 8'h0C;
  localparam logic [7:0] ADDR_YEND   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int         DEC_BITS    = 8;
  // control register fields
  localparam int XEN_BIT = 15;
  localparam int YEN_BIT = 14;
  localparam int XSEL_LO = 0;
  localparam int YSEL_LO = 4;
  localparam logic [3:0]  SEL_OFF    = 4'hF;
  localparam logic [15:0] CTRL_RST   = 16'h00FF;
  localparam logic [15:0] BOUND_RST  = 16'h0000;
  // ***********************************************
  // working registers and prefetch pointers
  // ***********************************************
  localparam int          NUM_W      = 16;
  localparam logic [3:0]  X_PTR_A    = 4'h8;
  localparam logic [3:0]  X_PTR_B    = 4'h9;
  localparam logic [3:0]  Y_PTR_A    = 4'hA;
  localparam logic [3:0]  Y_PTR_B    = 4'hB;
  localparam logic [15:0] WMAP_BASE  = 16'h0000;
  localparam int          WMAP_SHIFT = 1;
  localparam logic [1:0]  AHB_NONSEQ = 2'b10;
  // ***********************************************
  // addressing modes and carriers
  // ***********************************************
  typedef enum logic [1:0] {
    AM_DIRECT   = 2'b00,
    AM_INDIRECT = 2'b01,
    AM_MODIFIED = 2'b11,
    AM_INDEXED  = 2'b10
  } oasl_mode_type;

  typedef struct packed {
    logic          valid;
    oasl_mode_type mode;
    logic [3:0]    wreg;
    logic          writePhase;
    logic [15:0]   wrAddr;
  } oasl_dst_type;

  typedef struct packed {
    logic          valid;
    oasl_mode_type mode;
    logic [3:0]    wreg;
  } oasl_src_type;

  typedef struct packed {
    logic          valid;
    logic          xSelB;
    logic          ySelB;
    oasl_mode_type xMode;
    oasl_mode_type yMode;
    logic [1:0]    step;
    logic          stepNeg;
    logic [3:0]    offReg;
  } oasl_mac_type;

  typedef struct packed {
    oasl_mode_type srcMode;
    logic [3:0]    srcReg;
    oasl_mode_type dstMode;
    logic [3:0]    dstReg;
    logic [3:0]    offsetRegisterField;
  } oasl_mov_type;
endpackage
